// ---- logic/acs_regs.svh ----
/*
  Register offsets, field positions, reset values and widths of the
  converter status and special channel block.
  Assumes it is included by its bare name, once per compile unit.
*/
// Operation
// - The sequence-done flag, bit 7 of the status register, is set after every finished sequence.
// - That flag clears on a one written to it, any sequence-start write, or a result read with fast clear.
// - With edge triggering selected, a trigger edge during a running sequence sets the overrun flag in bit 5.
// - The trigger overrun flag clears on a one written, a setup register write, or a sequence-start write.
// - Writing a result slot whose conversion-done flag is still set sets the result overrun flag in bit 4.
// - The result overrun flag clears on a one written or on any sequence start, by write or by trigger.
// - Bits 3:0 of the status register show the 4-bit index of the slot taking the current result.
// - Outside FIFO mode the counter returns to zero at sequence start and end; in FIFO mode it carries on.
// - The counter wraps from its top value back to zero.
// - Any control register write that aborts or starts a conversion clears the counter, FIFO mode or not.
// - The status register is readable and writable at all times and writes never touch the counter.
// - The first test register reads unpredictable data and takes writes only in special modes.
// - The second test register is always read/write, and bits 7 and 6 read unpredictable.
// - Its bit 0 turns the channel code into a choice among internal special channels.
// - With that bit set and top code bit 0, codes 100, 101, 110 pick high, low and mid reference; others reserved.
// - Continuous mode repeats sequences, but not when external triggering is on.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define ACS_AW          3
`define ACS_DW          8
`define ACS_ADDR_STAT   3'h0
`define ACS_ADDR_TEST0  3'h1
`define ACS_ADDR_TEST1  3'h2
`define ACS_ADDR_IRQST  3'h3
`define ACS_ADDR_IRQMSK 3'h4

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define ACS_SEQ_DONE_BIT  7
`define ACS_TRIG_OVR_BIT  5
`define ACS_RES_OVR_BIT   4
`define ACS_CNT_MSB       3
`define ACS_SC_BIT        0
`define ACS_IRQ_SEQ_BIT   0
`define ACS_IRQ_TRIG_BIT  1
`define ACS_IRQ_RES_BIT   2
`define ACS_TEST1_WMASK   8'h3F

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACS_RST_BYTE    8'h00
`define ACS_RST_CNT     4'h0
`define ACS_RST_IRQ     3'h0

`endif

// ---- logic/acs_pkg.sv ----
/*
  Types shared by the converter status block.
  Assumes the user writes every reference as acs_pkg::name.
*/
package acs_pkg;

  // Register port request, one cycle per strobe
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } acs_req_t;

  // Mode bits held by the setup registers outside this block
  typedef struct packed {
    logic fast_flag_clear_select;
    logic trigger_level_select;
    logic external_trigger_enable;
    logic fifo_mode;
    logic scan_mode;
    logic special_mode;
  } acs_cfg_t;

  // One-cycle events from the sequence controller
  typedef struct packed {
    logic seq_done;
    logic seq_busy;
    logic trig_edge;
    logic trig_start;
    logic conv_step;
    logic result_write;
    logic slot_done_set;
    logic result_read;
    logic setup_write;
    logic start_write;
  } acs_evt_t;

  // Input source chosen by the channel code
  typedef enum logic [4:0] {
    ACS_SRC_EXT  = 5'h01,
    ACS_SRC_HIGH = 5'h02,
    ACS_SRC_LOW  = 5'h04,
    ACS_SRC_MID  = 5'h08,
    ACS_SRC_RSVD = 5'h10
  } acs_src_t;

  typedef struct packed {
    acs_src_t   src;
    logic [3:0] code;
  } acs_chan_t;

endpackage

// ---- logic/acs_status.sv ----
/*
  Status, counter and test registers of the converter sequence
  controller, with a masked interrupt over the three flags.
  Assumes all event and mode inputs come from logic on sys_clk,
  and that strobes on the register port are single cycles.
*/
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "acs_regs.svh"

module acs_status (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire acs_pkg::acs_req_t req,
  output logic [7:0]             rdata,
  input  wire acs_pkg::acs_cfg_t cfg,
  input  wire acs_pkg::acs_evt_t evt,
  input  wire logic [3:0]        channel_code_bits,
  output acs_pkg::acs_chan_t     chan_sel,
  output logic [3:0]             result_slot_counter,
  output logic                   special_channel_enable,
  output logic                   seq_rerun,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       wr_stat;
  logic       wr_test0;
  logic       wr_test1;
  logic       wr_irqst;
  logic       wr_irqmsk;
  logic       sw_start;

  assign wr_stat   = req.wr && (req.addr == `ACS_ADDR_STAT);
  assign wr_test0  = req.wr && (req.addr == `ACS_ADDR_TEST0);
  assign wr_test1  = req.wr && (req.addr == `ACS_ADDR_TEST1);
  assign wr_irqst  = req.wr && (req.addr == `ACS_ADDR_IRQST);
  assign wr_irqmsk = req.wr && (req.addr == `ACS_ADDR_IRQMSK);
  // Any new sequence start, software or trigger
  assign sw_start  = evt.start_write || evt.trig_start;

  // ----------------------------------------------------------------
  // Flag events
  // ----------------------------------------------------------------
  logic set_seq;
  logic set_trig;
  logic set_res;
  logic clr_seq;
  logic clr_trig;
  logic clr_res;

  assign set_seq  = evt.seq_done;
  assign set_trig = evt.trig_edge && evt.seq_busy && !cfg.trigger_level_select;
  assign set_res  = evt.result_write && evt.slot_done_set;
  assign clr_seq  = (wr_stat && req.wdata[`ACS_SEQ_DONE_BIT]) || evt.start_write ||
                    (evt.result_read && cfg.fast_flag_clear_select);
  assign clr_trig = (wr_stat && req.wdata[`ACS_TRIG_OVR_BIT]) || evt.setup_write ||
                    evt.start_write;
  assign clr_res  = (wr_stat && req.wdata[`ACS_RES_OVR_BIT]) || sw_start;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic seq_done_flag_r;
  logic trigger_overrun_flag_r;
  logic result_overrun_flag_r;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_done_flag_r        <= 1'b0;
      trigger_overrun_flag_r <= 1'b0;
      result_overrun_flag_r  <= 1'b0;
    end else begin
      seq_done_flag_r        <= set_seq  || (seq_done_flag_r && !clr_seq);
      trigger_overrun_flag_r <= set_trig || (trigger_overrun_flag_r && !clr_trig);
      result_overrun_flag_r  <= set_res  || (result_overrun_flag_r && !clr_res);
    end
  end

  // ----------------------------------------------------------------
  // Result slot counter
  // ----------------------------------------------------------------
  logic [3:0] cnt_r;
  logic       cnt_clr;

  // control writes clear always; seq edges outside FIFO mode
  assign cnt_clr = evt.setup_write || evt.start_write ||
                   (!cfg.fifo_mode && (evt.trig_start || evt.seq_done));

  // slot index; writes on the register port never reach it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= `ACS_RST_CNT;
    end else if (cnt_clr) begin
      cnt_r <= `ACS_RST_CNT;
    end else if (evt.conv_step) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign result_slot_counter = cnt_r;

  // ----------------------------------------------------------------
  // Test registers
  // ----------------------------------------------------------------
  logic [7:0] test0_r;
  logic [7:0] test1_r;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      test0_r <= `ACS_RST_BYTE;
    end else if (wr_test0 && cfg.special_mode) begin
      test0_r <= req.wdata;
    end
  end

  // always writable, top two bits not kept
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      test1_r <= `ACS_RST_BYTE;
    end else if (wr_test1) begin
      test1_r <= req.wdata & `ACS_TEST1_WMASK;
    end
  end

  assign special_channel_enable = test1_r[`ACS_SC_BIT];

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  function automatic acs_pkg::acs_src_t src_of(input logic sc, input logic [3:0] code);
    acs_pkg::acs_src_t s;
    s = acs_pkg::ACS_SRC_EXT;
    if (sc) begin
      unique case (code)
        4'h4:    s = acs_pkg::ACS_SRC_HIGH;
        4'h5:    s = acs_pkg::ACS_SRC_LOW;
        4'h6:    s = acs_pkg::ACS_SRC_MID;
        default: s = acs_pkg::ACS_SRC_RSVD;
      endcase
    end
    return s;
  endfunction

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_sel <= '{src: acs_pkg::ACS_SRC_EXT, code: 4'h0};
    end else begin
      chan_sel <= '{src: src_of(test1_r[`ACS_SC_BIT], channel_code_bits),
                    code: channel_code_bits};
    end
  end

  // ----------------------------------------------------------------
  // Continuous restart
  // ----------------------------------------------------------------
  // repeat only without external trigger
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_rerun <= 1'b0;
    end else begin
      seq_rerun <= evt.seq_done && cfg.scan_mode && !cfg.external_trigger_enable;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic [2:0] irq_st_r;
  logic [2:0] irq_msk_r;
  logic [2:0] irq_set;

  assign irq_set = {set_res, set_trig, set_seq};

  // Sticky, one written clears, set wins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_st_r <= `ACS_RST_IRQ;
    end else begin
      irq_st_r <= irq_set | (irq_st_r & ~(wr_irqst ? req.wdata[2:0] : 3'h0));
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_msk_r <= `ACS_RST_IRQ;
    end else if (wr_irqmsk) begin
      irq_msk_r <= req.wdata[2:0];
    end
  end

  assign irq = |(irq_st_r & irq_msk_r);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  // Unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (req.addr)
      `ACS_ADDR_STAT:   rd_mux = {seq_done_flag_r, 1'b0, trigger_overrun_flag_r,
                                  result_overrun_flag_r, cnt_r};
      `ACS_ADDR_TEST0:  rd_mux = test0_r;
      `ACS_ADDR_TEST1:  rd_mux = test1_r;
      `ACS_ADDR_IRQST:  rd_mux = {5'h00, irq_st_r};
      `ACS_ADDR_IRQMSK: rd_mux = {5'h00, irq_msk_r};
      default:          rd_mux = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= req.rd ? rd_mux : 8'h00;
    end
  end

endmodule // acs_status

// ---- tb/acs_status_chk.sv ----
/*
  Port checker for acs_status.
  Assumes it is bound into every acs_status instance.
*/
`timescale 1ns/1ps
module acs_status_chk (
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  input wire acs_pkg::acs_req_t  req,
  input wire logic [7:0]         rdata,
  input wire acs_pkg::acs_cfg_t  cfg,
  input wire acs_pkg::acs_evt_t  evt,
  input wire logic [3:0]         channel_code_bits,
  input wire acs_pkg::acs_chan_t chan_sel,
  input wire logic [3:0]         result_slot_counter,
  input wire logic               special_channel_enable,
  input wire logic               seq_rerun,
  input wire logic               irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic clr;
  // Every cause of a counter clear, which beats a step
  assign clr = evt.setup_write | evt.start_write | (!cfg.fifo_mode & (evt.trig_start | evt.seq_done));

  property p_cnt_clr; evt.setup_write || evt.start_write |=> result_slot_counter == 4'h0; endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter kept after control write");
  property p_seq_clr; !cfg.fifo_mode && (evt.trig_start || evt.seq_done) |=> result_slot_counter == 4'h0; endproperty
  a_seq_clr: assert property (p_seq_clr) else $error("counter kept at sequence edge");
  property p_step; evt.conv_step && !clr |=> result_slot_counter == $past(result_slot_counter) + 4'h1; endproperty
  a_step: assert property (p_step) else $error("counter step wrong");
  property p_stat_wr; req.wr && req.addr == 3'h0 && !evt.conv_step && !clr |=> $stable(result_slot_counter); endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write moved counter");
  property p_rerun; evt.seq_done && cfg.scan_mode |=> seq_rerun == !$past(cfg.external_trigger_enable); endproperty
  a_rerun: assert property (p_rerun) else $error("rerun pulse wrong");
  property p_sc_wr; req.wr && req.addr == 3'h2 |=> special_channel_enable == $past(req.wdata[0]); endproperty
  a_sc_wr: assert property (p_sc_wr) else $error("special enable not written");
  property p_ext; !special_channel_enable && !req.wr |=> chan_sel == {acs_pkg::ACS_SRC_EXT, $past(channel_code_bits)}; endproperty
  a_ext: assert property (p_ext) else $error("external source not chosen");
  property p_low; special_channel_enable && !req.wr && channel_code_bits == 4'h5 |=> chan_sel.src == acs_pkg::ACS_SRC_LOW; endproperty
  a_low: assert property (p_low) else $error("low reference not chosen");

  c_wrap: cover property (evt.conv_step && result_slot_counter == 4'hF);
  c_scan: cover property (evt.seq_done && cfg.scan_mode);
  c_mid: cover property (special_channel_enable && channel_code_bits == 4'h6);
endmodule // acs_status_chk

bind acs_status acs_status_chk i_acs_status_chk (.sys_clk, .sys_rst, .req, .rdata, .cfg, .evt, .channel_code_bits,
  .chan_sel, .result_slot_counter, .special_channel_enable, .seq_rerun, .irq);

// ---- tb/acs_status_tb.sv ----
/*
  Self-checking bench for acs_status.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/1ps
module acs_status_tb;
  localparam logic [9:0] DONE = 10'h200, BUSY = 10'h100, EDGE = 10'h080, TST = 10'h040, STEP = 10'h020;
  localparam logic [9:0] RWR = 10'h010, SLOT = 10'h008, RRD = 10'h004, SETUP = 10'h002, START = 10'h001;
  logic               sys_clk, sys_rst, special_channel_enable, seq_rerun, irq, pend, a, b;
  acs_pkg::acs_req_t  req;
  acs_pkg::acs_cfg_t  cfg;
  acs_pkg::acs_evt_t  evt;
  acs_pkg::acs_chan_t chan_sel;
  acs_pkg::acs_src_t  s;
  logic [3:0]         channel_code_bits, result_slot_counter;
  logic [7:0]         rdata, d, exp_q[$];
  int                 err_count, total_checks, cyc, n;

  acs_status i_acs_status (.sys_clk, .sys_rst, .req, .rdata, .cfg, .evt, .channel_code_bits, .chan_sel,
    .result_slot_counter, .special_channel_enable, .seq_rerun, .irq);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Bus cycles; an idle edge follows so strobes never double up
  task automatic wr(input logic [2:0] ad, input logic [7:0] wd);
    req <= '{1'b1, 1'b0, ad, wd};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] ad, input logic [7:0] want);
    exp_q.push_back(want);
    req <= '{1'b0, 1'b1, ad, 8'h00};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask
  // One event pulse; rerun is caught in the cycle it stands
  task automatic ev(input logic [9:0] e);
    evt <= acs_pkg::acs_evt_t'(e);
    @(posedge sys_clk);
    evt <= '0;
    #1 a = seq_rerun;
    @(posedge sys_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (pend) check(rdata, exp_q.pop_front());
    pend = req.rd;
    cyc++;
    if (cyc > 4000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    sys_rst = 1'b1; req = '0; cfg = '0; evt = '0; channel_code_bits = 4'h0;
    pend = 1'b0; cyc = 0; err_count = 0; total_checks = 0;
    void'($urandom(32'h2c1ef448));
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
    // Sequence flag, zero write, then each clear
    ev(DONE); wr(0, 8'h00); rd(0, 8'h80);
    wr(0, 8'h80); rd(0, 8'h00);
    ev(DONE); ev(START); rd(0, 8'h00);
    cfg.fast_flag_clear_select <= 1'b1; ev(DONE); ev(RRD); rd(0, 8'h00);
    cfg <= '0;
    // Set and clear in one cycle: set wins
    evt <= acs_pkg::acs_evt_t'(DONE);
    req <= '{1'b1, 1'b0, 3'h0, 8'h80};
    @(posedge sys_clk);
    evt <= '0; req <= '0;
    @(posedge sys_clk);
    rd(0, 8'h80); wr(0, 8'h80);
    for (int i = 0; i < 2; i++) begin
      cfg <= '{1'b0, 1'b0, i[0], 1'b0, 1'b1, 1'b0};
      ev(DONE); check(a, !i[0]);
    end
    cfg <= '0; wr(0, 8'h80);
    // Trigger overrun and its refusals
    ev(EDGE | BUSY); rd(0, 8'h20); ev(SETUP); rd(0, 8'h00);
    ev(EDGE); cfg.trigger_level_select <= 1'b1; ev(EDGE | BUSY); rd(0, 8'h00);
    cfg <= '0; ev(EDGE | BUSY); wr(0, 8'h20); ev(EDGE | BUSY); ev(START); rd(0, 8'h00);
    // Result overrun
    ev(RWR); rd(0, 8'h00); ev(RWR | SLOT); rd(0, 8'h10); ev(TST); rd(0, 8'h00);
    ev(RWR | SLOT); wr(0, 8'h10); rd(0, 8'h00);
    // Counter steps, wrap, modes and clears
    n = $urandom_range(30, 17);
    repeat (n) ev(STEP);
    wr(0, 8'hFF); rd(0, 8'(n % 16));
    check(9'(result_slot_counter), 9'(n % 16));
    cfg.fifo_mode <= 1'b1; ev(DONE); ev(TST); rd(0, 8'h80 | 8'(n % 16));
    ev(SETUP); rd(0, 8'h80); ev(STEP); cfg.fifo_mode <= 1'b0; ev(DONE); rd(0, 8'h80);
    // Interrupt mask flips the level, clear drops it
    wr(3, 8'h07); ev(DONE); rd(3, 8'h01); wr(4, 8'h00); #1 b = irq;
    wr(4, 8'h07); #1 check(irq ^ b, 1'b1);
    wr(3, 8'h01); #1 check(irq, 1'b0);
    // Test registers
    wr(1, 8'h5A); rd(1, 8'h00); cfg.special_mode <= 1'b1; wr(1, 8'h5A); rd(1, 8'h5A);
    d = 8'($urandom); wr(2, d); rd(2, d & 8'h3F); wr(2, 8'h01);
    for (int i = 0; i < 17; i++) begin
      if (i == 16) wr(2, 8'h00);
      @(posedge sys_clk);
      channel_code_bits <= 4'(i);
      @(posedge sys_clk);
      s = i == 16 ? acs_pkg::ACS_SRC_EXT : i == 4 ? acs_pkg::ACS_SRC_HIGH : i == 5 ? acs_pkg::ACS_SRC_LOW :
          i == 6 ? acs_pkg::ACS_SRC_MID : acs_pkg::ACS_SRC_RSVD;
      #1 check(chan_sel, {s, 4'(i)});
    end
    repeat (2) @(posedge sys_clk);
    close_out();
  end
endmodule // acs_status_tb
